// File: verification/phy_test_diag_regs_bench.sv
module phy_test_diag_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import phy_test_diag_pkg::*;

  logic core_clk_i, reset_i, clk_en_i, wr_i, rd_i;
  logic [7:0] addr_i;
  logic [15:0] wdata_i, rdata_o, d;
  logic polarity_inverted_i, status_read_i, polarity_status_o, prbs_byte_error_i;
  logic count_mode_i, cable_done_i, cable_fail_i, cable_start_o, irq_o;
  rx_tuning_t rx_tuning_o;
  selftest_cfg_t selftest_cfg_o;
  int miscompares = 0;
  int tests_run = 0;

  phy_test_diag_regs u_dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .polarity_inverted_i(polarity_inverted_i), .status_read_i(status_read_i),
    .polarity_status_o(polarity_status_o), .prbs_byte_error_i(prbs_byte_error_i),
    .count_mode_i(count_mode_i), .cable_done_i(cable_done_i), .cable_fail_i(cable_fail_i),
    .cable_start_o(cable_start_o), .rx_tuning_o(rx_tuning_o),
    .selftest_cfg_o(selftest_cfg_o), .irq_o(irq_o));

  // Free-running 250 MHz clock
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One-cycle write strobe; a gap cycle follows so strobes never overlap
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge core_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : reg_wr

  // Read data only stands in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge core_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask : reg_rd

  task automatic test_reset_values;
    reg_rd(ADDR_TENBASE, d); chk(d, 16'h0000);
    reg_rd(ADDR_COUNT_GAP, d); chk(d, 16'h007D);
    reg_rd(ADDR_PKT_LEN, d); chk(d, 16'h05EE);
    reg_rd(ADDR_CABLE, d); chk(d, 16'h0000);
    reg_rd(8'h1D, d); chk(d, 16'h0000);
    chk({5'h00, selftest_cfg_o.packet_bytes}, 16'h05EE);
    $display("test reset_values done");
  endtask : test_reset_values

  task automatic test_rx_tuning;
    // Reserved top bits dropped, squelch 13 stored but driven as 8
    reg_wr(ADDR_TENBASE, 16'hFA81);
    chk({9'h000, rx_tuning_o}, {9'h000, 1'b1, 4'h8, 1'b1, 1'b1});
    reg_rd(ADDR_TENBASE, d); chk(d, 16'h3A81);
    reg_wr(ADDR_TENBASE, 16'h1000);
    chk({9'h000, rx_tuning_o}, {9'h000, 1'b0, 4'h8, 1'b0, 1'b0});
    $display("test rx_tuning done");
  endtask : test_rx_tuning

  task automatic test_polarity;
    @(posedge core_clk_i);
    polarity_inverted_i <= 1'b1;
    @(posedge core_clk_i);
    polarity_inverted_i <= 1'b0;
    status_read_i <= 1'b1;
    @(posedge core_clk_i);
    status_read_i <= 1'b0;
    #1 chk({15'h0000, polarity_status_o}, 16'h0001);
    chk({15'h0000, irq_o}, 16'h0000);
    reg_wr(ADDR_IRQ_MASK, 16'h0001);
    chk({15'h0000, irq_o}, 16'h0001);
    reg_wr(ADDR_IRQ_STATUS, 16'h0001);
    chk({15'h0000, irq_o}, 16'h0000);
    reg_rd(ADDR_TENBASE, d); chk(d, 16'h1010);
    chk({15'h0000, polarity_status_o}, 16'h0000);
    reg_rd(ADDR_TENBASE, d); chk(d, 16'h1000);
    $display("test polarity done");
  endtask : test_polarity

  task automatic errors(input int n);
    @(posedge core_clk_i);
    prbs_byte_error_i <= 1'b1;
    repeat (n) @(posedge core_clk_i);
    prbs_byte_error_i <= 1'b0;
  endtask : errors

  task automatic test_counter;
    errors(3);
    reg_wr(ADDR_COUNT_GAP, 16'h807D);
    reg_rd(ADDR_COUNT_GAP, d); chk(d, 16'h037D);
    reg_wr(ADDR_COUNT_GAP, 16'h807D);
    reg_rd(ADDR_COUNT_GAP, d); chk(d, 16'h007D);
    errors(300);
    reg_wr(ADDR_COUNT_GAP, 16'h807D);
    reg_rd(ADDR_COUNT_GAP, d); chk(d, 16'hFF7D);
    reg_wr(ADDR_IRQ_MASK, 16'h0008);
    chk({15'h0000, irq_o}, 16'h0001);
    reg_wr(ADDR_IRQ_STATUS, 16'h000F);
    chk({15'h0000, irq_o}, 16'h0000);
    reg_wr(ADDR_COUNT_GAP, 16'h00FF);
    chk({8'h00, selftest_cfg_o.gap_bytes}, 16'h00FF);
    // Clock enable low must swallow the write
    @(posedge core_clk_i);
    clk_en_i <= 1'b0;
    reg_wr(ADDR_COUNT_GAP, 16'h0001);
    @(posedge core_clk_i);
    clk_en_i <= 1'b1;
    reg_rd(ADDR_COUNT_GAP, d); chk(d, 16'hFFFF);
    $display("test counter done");
  endtask : test_counter

  task automatic test_length;
    reg_wr(ADDR_PKT_LEN, 16'hFFFF);
    reg_rd(ADDR_PKT_LEN, d); chk(d, 16'h07FF);
    chk({5'h00, selftest_cfg_o.packet_bytes}, 16'h07FF);
    $display("test length done");
  endtask : test_length

  task automatic cable_run(input logic fail, input logic [15:0] exp);
    reg_wr(ADDR_CABLE, 16'h8000);
    chk({15'h0000, cable_start_o}, 16'h0001);
    reg_rd(ADDR_CABLE, d); chk(d, 16'h8000);
    @(posedge core_clk_i);
    cable_done_i <= 1'b1;
    cable_fail_i <= fail;
    @(posedge core_clk_i);
    cable_done_i <= 1'b0;
    cable_fail_i <= 1'b0;
    #1 chk({15'h0000, cable_start_o}, 16'h0000);
    reg_rd(ADDR_CABLE, d); chk(d, exp);
  endtask : cable_run

  task automatic test_cable;
    cable_run(1'b1, 16'h0003);
    cable_run(1'b0, 16'h0002);
    reg_rd(ADDR_IRQ_STATUS, d); chk(d, 16'h0006);
    $display("test cable done");
  endtask : test_cable

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  // Whole run needs well under 2000 cycles
  initial begin
    #40000;
    miscompares++;
    test_done();
  end

  initial begin
    reset_i = 1'b1;
    clk_en_i = 1'b1;
    {wr_i, rd_i, polarity_inverted_i, status_read_i, prbs_byte_error_i} = 5'h00;
    {count_mode_i, cable_done_i, cable_fail_i} = 3'h0;
    addr_i = 8'h00;
    wdata_i = 16'h0000;
    repeat (16) @(posedge core_clk_i);
    reset_i <= 1'b0;
    test_reset_values();
    test_rx_tuning();
    test_polarity();
    test_counter();
    test_length();
    test_cable();
    test_done();
  end
endmodule : phy_test_diag_regs_bench

// File: verilog/phy_test_diag_pkg.sv
package phy_test_diag_pkg;
  // Register word offsets
  localparam logic [7:0] ADDR_TENBASE = 8'h1A;
  localparam logic [7:0] ADDR_COUNT_GAP = 8'h1B;
  localparam logic [7:0] ADDR_PKT_LEN = 8'h1C;
  localparam logic [7:0] ADDR_CABLE = 8'h1E;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h21;
  // Field positions
  localparam int THRESH_BIT = 13;
  localparam int SQUELCH_LSB = 9;
  localparam int LINK_PULSE_BIT = 7;
  localparam int POLARITY_BIT = 4;
  localparam int JABBER_BIT = 0;
  localparam int COUNT_LSB = 8;
  localparam int LATCH_BIT = 15;
  localparam int START_BIT = 15;
  localparam int DONE_BIT = 1;
  localparam int FAIL_BIT = 0;
  // Reset values and limits
  localparam logic [3:0] SQUELCH_RESET = 4'h0;
  localparam logic [3:0] SQUELCH_MAX = 4'h8;
  localparam logic [7:0] GAP_RESET = 8'h7D;
  localparam logic [10:0] LEN_RESET = 11'h5EE;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  // Interrupt status bit positions and width
  localparam int IRQ_POLARITY = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_FAIL = 2;
  localparam int IRQ_SAT = 3;
  localparam int IRQ_W = 4;

  // Receiver tuning outputs toward the analog front end
  typedef struct packed {
    logic lower_threshold;
    logic [3:0] squelch;
    logic link_pulse_off;
    logic jabber_off;
  } rx_tuning_t;

  // Self-test generator settings
  typedef struct packed {
    logic [7:0] gap_bytes;
    logic [10:0] packet_bytes;
  } selftest_cfg_t;
endpackage : phy_test_diag_pkg

// File: verilog/phy_test_diag_regs.sv
// Contract
// R01 - Bit 13 lowers receiver threshold
// R02 - Bits 12:9 select squelch level
// R03 - Bit 7 stops normal link pulses
// R04 - Bit 4 mirrors inverted polarity flag
// R05 - Control register read clears polarity copies
// R06 - Bit 0 disables jabber protection
// R07 - Bits 15:8 hold errored byte count
// R08 - Write bit 15 latches, clears counter
// R09 - Counter saturates at FF in mode 0
// R10 - Bits 7:0 set gap, reset 7D
// R11 - Bits 10:0 set length, reset 5EE
// R12 - Start bit cleared when done rises
// R13 - Done flag reads measurement complete
// R14 - Fail flag reads measurement failed
// R15 - Software uses 16-bit management accesses
//
// The strobed register port was left to the implementer.
module phy_test_diag_regs (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic polarity_inverted_i,
  input wire logic status_read_i,
  output logic polarity_status_o,
  input wire logic prbs_byte_error_i,
  input wire logic count_mode_i,
  input wire logic cable_done_i,
  input wire logic cable_fail_i,
  output logic cable_start_o,
  output phy_test_diag_pkg::rx_tuning_t rx_tuning_o,
  output phy_test_diag_pkg::selftest_cfg_t selftest_cfg_o,
  output logic irq_o
);
  import phy_test_diag_pkg::*;

  logic lower_threshold;
  logic [3:0] squelch;
  logic link_pulse_off;
  logic jabber_off;
  logic polarity;
  logic [7:0] run_count;
  logic [7:0] held_count;
  logic [7:0] gap_bytes;
  logic [10:0] packet_bytes;
  logic start;
  logic done;
  logic fail;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_event;
  logic done_d;
  logic sat_d;
  logic wr_tenbase;
  logic wr_count_gap;
  logic wr_pkt_len;
  logic wr_cable;
  logic rd_tenbase;
  logic latch_req;
  logic [15:0] next_rdata;

  // Access decode, all gated by the clock enable
  assign wr_tenbase = clk_en_i && wr_i && addr_i == ADDR_TENBASE;
  assign wr_count_gap = clk_en_i && wr_i && addr_i == ADDR_COUNT_GAP;
  assign wr_pkt_len = clk_en_i && wr_i && addr_i == ADDR_PKT_LEN;
  assign wr_cable = clk_en_i && wr_i && addr_i == ADDR_CABLE;
  assign rd_tenbase = clk_en_i && rd_i && addr_i == ADDR_TENBASE;
  assign latch_req = wr_count_gap && wdata_i[LATCH_BIT]; // [R08]

  // Receiver tuning controls
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lower_threshold <= 1'b0;
      squelch <= SQUELCH_RESET;
      link_pulse_off <= 1'b0;
      jabber_off <= 1'b0;
    end else if (wr_tenbase) begin
      lower_threshold <= wdata_i[THRESH_BIT]; // [R01]
      squelch <= wdata_i[SQUELCH_LSB +: 4]; // [R02]
      link_pulse_off <= wdata_i[LINK_PULSE_BIT]; // [R03]
      jabber_off <= wdata_i[JABBER_BIT]; // [R06]
    end
  end

  // Squelch codes above 1000 are undefined, so they clamp to the top level
  assign rx_tuning_o.lower_threshold = lower_threshold; // [R01]
  assign rx_tuning_o.squelch = (squelch > SQUELCH_MAX) ? SQUELCH_MAX : squelch; // [R02]
  assign rx_tuning_o.link_pulse_off = link_pulse_off; // [R03]
  assign rx_tuning_o.jabber_off = jabber_off; // [R06]

  // Sticky polarity copy; a new detection wins over the clearing read
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      polarity <= 1'b0;
    end else if (clk_en_i) begin
      if (polarity_inverted_i) begin
        polarity <= 1'b1; // [R04]
      end else if (rd_tenbase) begin
        polarity <= 1'b0; // [R05]
      end
    end
  end
  // Same flop feeds the general status copy, so reads of that leave it alone
  assign polarity_status_o = polarity; // [R04] [R05]

  // Running error counter; mode 1 lets it wrap
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      run_count <= 8'h00;
    end else if (clk_en_i) begin
      if (latch_req) begin
        run_count <= 8'h00; // [R08]
      end else if (prbs_byte_error_i && !(run_count == COUNT_MAX && !count_mode_i)) begin
        run_count <= run_count + 8'h01; // [R07] [R09]
      end
    end
  end

  // Snapshot taken by the latch write, shown on reads
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      held_count <= 8'h00;
    end else if (latch_req) begin
      held_count <= run_count; // [R08]
    end
  end

  // Self-test generator settings
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      gap_bytes <= GAP_RESET;
      packet_bytes <= LEN_RESET;
    end else begin
      if (wr_count_gap) begin
        gap_bytes <= wdata_i[7:0]; // [R10]
      end
      if (wr_pkt_len) begin
        packet_bytes <= wdata_i[10:0]; // [R11]
      end
    end
  end
  assign selftest_cfg_o.gap_bytes = gap_bytes; // [R10]
  assign selftest_cfg_o.packet_bytes = packet_bytes; // [R11]

  // Cable test start, done and fail; completion clears start itself
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      start <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
    end else if (clk_en_i) begin
      if (start && cable_done_i) begin
        start <= 1'b0; // [R12]
        done <= 1'b1; // [R13]
        fail <= cable_fail_i; // [R14]
      end else if (wr_cable && wdata_i[START_BIT]) begin
        // A fresh run forgets the previous outcome
        start <= 1'b1; // [R12]
        done <= 1'b0; // [R13]
        fail <= 1'b0; // [R14]
      end else if (wr_cable) begin
        start <= 1'b0;
      end
    end
  end
  assign cable_start_o = start;

  // Interrupt events: polarity, done, fail, counter saturation
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      done_d <= 1'b0;
      sat_d <= 1'b0;
    end else if (clk_en_i) begin
      done_d <= done;
      sat_d <= run_count == COUNT_MAX;
    end
  end
  assign irq_event[IRQ_POLARITY] = polarity_inverted_i && !polarity;
  assign irq_event[IRQ_DONE] = done && !done_d;
  assign irq_event[IRQ_FAIL] = done && !done_d && fail;
  assign irq_event[IRQ_SAT] = run_count == COUNT_MAX && !sat_d;

  // Write-one-to-clear status; a new event wins over the clear
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_status <= '0;
      irq_mask <= '0;
    end else if (clk_en_i) begin
      if (wr_i && addr_i == ADDR_IRQ_MASK) begin
        irq_mask <= wdata_i[IRQ_W-1:0];
      end
      if (wr_i && addr_i == ADDR_IRQ_STATUS) begin
        irq_status <= (irq_status & ~wdata_i[IRQ_W-1:0]) | irq_event;
      end else begin
        irq_status <= irq_status | irq_event;
      end
    end
  end
  assign irq_o = |(irq_status & irq_mask);

  // Read mux; reserved bits and unmapped addresses read zero
  always_comb begin
    next_rdata = 16'h0000;
    case (addr_i)
      ADDR_TENBASE: begin
        next_rdata[THRESH_BIT] = lower_threshold;
        next_rdata[SQUELCH_LSB +: 4] = squelch;
        next_rdata[LINK_PULSE_BIT] = link_pulse_off;
        next_rdata[POLARITY_BIT] = polarity; // [R04]
        next_rdata[JABBER_BIT] = jabber_off;
      end
      ADDR_COUNT_GAP: begin
        next_rdata[COUNT_LSB +: 8] = held_count; // [R07]
        next_rdata[7:0] = gap_bytes;
      end
      ADDR_PKT_LEN: next_rdata[10:0] = packet_bytes;
      ADDR_CABLE: begin
        next_rdata[START_BIT] = start;
        next_rdata[DONE_BIT] = done; // [R13]
        next_rdata[FAIL_BIT] = fail; // [R14]
      end
      ADDR_IRQ_STATUS: next_rdata[IRQ_W-1:0] = irq_status;
      ADDR_IRQ_MASK: next_rdata[IRQ_W-1:0] = irq_mask;
      default: next_rdata = 16'h0000;
    endcase
  end

  // Read data stands one cycle after an enabled strobe; other enabled cycles return zero
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= 16'h0000;
    end else if (clk_en_i) begin
      rdata_o <= rd_i ? next_rdata : 16'h0000; // [R15]
    end
  end

  // Start falls in the cycle after done is accepted
  property p_start_clears;
    @(posedge core_clk_i) disable iff (reset_i)
      (clk_en_i && start && cable_done_i) |=> (!start && done);
  endproperty
  chk_start_self_clear: assert property (p_start_clears) // [R12]
    else $error("start bit not cleared on done");

  chk_done_fail_pair: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (fail |-> done)) // [R14]
    else $error("fail set without done");

  chk_polarity_read_clear: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (rd_tenbase && !polarity_inverted_i) |=> !polarity) // [R05]
    else $error("polarity not cleared by read");

  chk_polarity_sticky: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (clk_en_i && polarity_inverted_i) |=> polarity_status_o) // [R04]
    else $error("polarity detection lost");

  chk_count_saturate: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (run_count == COUNT_MAX && !count_mode_i && !latch_req) |=> run_count == COUNT_MAX) // [R09]
    else $error("counter left saturation");

  sequence s_latch;
    latch_req;
  endsequence
  chk_count_latch: assert property (@(posedge core_clk_i) disable iff (reset_i)
    s_latch |=> (held_count == $past(run_count) && run_count <= 8'h01)) // [R08]
    else $error("latch did not snapshot and clear");

  chk_count_step: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (clk_en_i && prbs_byte_error_i && !latch_req && run_count != COUNT_MAX)
      |=> run_count == $past(run_count) + 8'h01) // [R07]
    else $error("error count did not advance");

  chk_gap_write: assert property (@(posedge core_clk_i) disable iff (reset_i)
    wr_count_gap |=> selftest_cfg_o.gap_bytes == $past(wdata_i[7:0])) // [R10]
    else $error("gap field not written");

  chk_len_write: assert property (@(posedge core_clk_i) disable iff (reset_i)
    wr_pkt_len |=> selftest_cfg_o.packet_bytes == $past(wdata_i[10:0])) // [R11]
    else $error("length field not written");

  chk_tuning_write: assert property (@(posedge core_clk_i) disable iff (reset_i)
    wr_tenbase |=> (rx_tuning_o.lower_threshold == $past(wdata_i[13])
      && rx_tuning_o.link_pulse_off == $past(wdata_i[7])
      && rx_tuning_o.jabber_off == $past(wdata_i[0]))) // [R01]
    else $error("tuning bits not written");

  chk_squelch_range: assert property (@(posedge core_clk_i) disable iff (reset_i)
    rx_tuning_o.squelch <= SQUELCH_MAX) // [R02]
    else $error("squelch code out of range");

  chk_jabber_hold: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !wr_tenbase |=> $stable(rx_tuning_o.jabber_off)) // [R06]
    else $error("jabber control changed without write");

  chk_done_hold: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (done && !wr_cable) |=> done) // [R13]
    else $error("done flag dropped");

  chk_read_timing: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (clk_en_i && !rd_i) |=> rdata_o == 16'h0000) // [R15]
    else $error("read data outside read slot");

  chk_link_pulse: assert property (@(posedge core_clk_i) disable iff (reset_i)
    rx_tuning_o.link_pulse_off == link_pulse_off) // [R03]
    else $error("link pulse control mismatch");

  // Steps of a cable run and of a register read
  sequence s_cable_finish;
    clk_en_i && start && cable_done_i;
  endsequence
  sequence s_cable_launch;
    clk_en_i && wr_cable && wdata_i[START_BIT] && !(start && cable_done_i);
  endsequence
  sequence s_read_at(logic [7:0] a);
    clk_en_i && rd_i && addr_i == a;
  endsequence

  // Outcome is captured with the done indication
  chk_fail_capture: assert property (@(posedge core_clk_i) disable iff (reset_i)
    s_cable_finish |=> fail == $past(cable_fail_i)) // [R14]
    else $error("fail flag not captured with done");

  // A start write launches a fresh run with a clean outcome
  chk_start_launch: assert property (@(posedge core_clk_i) disable iff (reset_i)
    s_cable_launch |=> (start && !done && !fail)) // [R12]
    else $error("start write did not launch a clean run");

  // Done and fail reach the read port as stored
  chk_done_read: assert property (@(posedge core_clk_i) disable iff (reset_i)
    s_read_at(ADDR_CABLE) |=> rdata_o[1:0] == $past({done, fail})) // [R13]
    else $error("cable flags misread");

  // Polarity copy shows on the control register read
  chk_polarity_read: assert property (@(posedge core_clk_i) disable iff (reset_i)
    s_read_at(ADDR_TENBASE) |=> rdata_o[POLARITY_BIT] == $past(polarity)) // [R04]
    else $error("polarity bit misread");

  // Reads show the snapshot, never the live count
  chk_count_read: assert property (@(posedge core_clk_i) disable iff (reset_i)
    s_read_at(ADDR_COUNT_GAP) |=> rdata_o[15:8] == $past(held_count)) // [R07]
    else $error("held count misread");

  // Mode 1 lets the counter roll over
  chk_count_wrap: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (clk_en_i && prbs_byte_error_i && count_mode_i && !latch_req
      && run_count == COUNT_MAX) |=> run_count == 8'h00) // [R09]
    else $error("counter did not wrap in mode 1");

  // Configuration holds between writes
  chk_gap_hold: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !wr_count_gap |=> $stable(selftest_cfg_o.gap_bytes)) // [R10]
    else $error("gap changed without write");

  chk_len_hold: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !wr_pkt_len |=> $stable(selftest_cfg_o.packet_bytes)) // [R11]
    else $error("length changed without write");

  chk_threshold_hold: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !wr_tenbase |=> $stable(rx_tuning_o.lower_threshold)) // [R01]
    else $error("threshold changed without write");

  // Legal squelch codes pass straight through
  chk_squelch_write: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (wr_tenbase && wdata_i[12:9] <= SQUELCH_MAX)
      |=> rx_tuning_o.squelch == $past(wdata_i[12:9])) // [R02]
    else $error("squelch code not applied");

  // Done rising must set its interrupt status bit
  chk_done_irq: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (clk_en_i && done && !done_d) |=> irq_status[IRQ_DONE]) // [R13]
    else $error("done event not recorded");

  // Clock enable low freezes the counter and the flags
  chk_enable_freeze: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !clk_en_i |=> ($stable(run_count) && $stable(polarity) && $stable(start))) // [R08]
    else $error("state moved with clock enable low");
endmodule : phy_test_diag_regs
